// >>> u9bg_top.sv
// Serial port with nine-bit modes and baud-rate generation
// Summary of operation
// - Nine-bit frame: start low, eight data LSB first, ninth bit, stop high.
// - Fixed nine-bit mode runs at clock/32, or clock/16 when doubled.
// - Transmit load puts buffer data LSB first, ninth bit in ninth slot.
// - Shifting out starts only at the next baud tick after trigger.
// - Transmit-done flag sets when the stop bit is driven.
// - On receive, data to buffer, ninth bit stored, receive-done set.
// - Frame kept only if receive-done clear and stop bit high.
// - Both mode bits set: nine-bit mode rated by Timer 1 or Timer 2.
// - Upper mode bit set, lower clear: fixed-rate nine-bit mode.
// - A write to the data buffer starts a transmission unless the eight-entry queue is full.
// - Shift mode receives when flag clear and enabled; others on start bit.
// - Shift-register mode bit rate is clock divided by twelve.
// - Timer 1 rate: overflow rate times two-to-doubling over 32.
// - Timer 2 rate: sixteen overflows per bit, 16-bit reload value.
// - Transmit and receive clock selects route Timer 2 independently.
// - Timer 2 as rate generator counts every two clock cycles.
// - Dedicated enable bit overrides doubling and Timer 2 selects.
// - Divider exponent in bits 2..0; bits 6..3 ignored on write.
// - Dedicated rate is 2*clock over 2^(div-1) times (fraction+64).
// - Fractional divider holds six bits; bits 7 and 6 ignored.
// - Outside shift mode, receiver starts on a falling edge and rejects a start bit sampled high at mid-bit.
`timescale 1ns/1ps
`default_nettype none
`include "u9bg_map.svh"
module u9bg_top (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        RESET,
   // Register port
   input  wire logic [7:0]  SFR_ADDR,
   input  wire logic        SFR_WR,
   input  wire logic [7:0]  SFR_WDATA,
   input  wire logic        SFR_RD,
   output logic [7:0]       SFR_RDATA,
   output logic             TX_FIFO_READY,
   // Rate sources and selects
   input  wire logic        RATE_DOUBLE,
   input  wire logic        TX_CLK_SEL,
   input  wire logic        RX_CLK_SEL,
   input  wire logic        T1_OVF,
   input  wire logic [15:0] T2_RELOAD,
   // Serial pins
   output logic             TXD,
   input  wire logic        RXD_I,
   output logic             RXD_O,
   output logic             RXD_OE
);
   // ----------------------------------------
   // Register file
   // ----------------------------------------
   logic [7:0] sctl_q, sctl_d;
   logic [7:0] rbuf_q, rbuf_d;
   logic [5:0] fdiv_q, fdiv_d;
   logic       bten_q, bten_d;
   logic [2:0] btdiv_q, btdiv_d;
   logic [7:0] rdata_q, rdata_d;
   logic       wr_sctl, wr_serial_data_buffer;
   logic       tx_set, rx_ok, rx_final, rx_m0_done;
   logic [7:0] rx_data;
   logic       rx_nin;
   logic [1:0] mode;
   logic       m0, nine;

   assign mode    = {sctl_q[`U9BG_SCTL_MODE_HI], sctl_q[`U9BG_SCTL_MODE_LO]};
   assign m0      = (mode == 2'b00);
   assign nine    = mode[1];
   assign wr_sctl = SFR_WR && (SFR_ADDR == `U9BG_ADDR_SCTL);
   assign wr_serial_data_buffer = SFR_WR && (SFR_ADDR == `U9BG_ADDR_SERIAL_DATA_BUFFER);

   always_comb begin
      sctl_d  = sctl_q;
      rbuf_d  = rbuf_q;
      fdiv_d  = fdiv_q;
      bten_d  = bten_q;
      btdiv_d = btdiv_q;
      rdata_d = rdata_q;
      if (wr_sctl) begin
         sctl_d = SFR_WDATA;
      end
      if (SFR_WR && (SFR_ADDR == `U9BG_ADDR_FDIV)) begin
         fdiv_d = SFR_WDATA[5:0];
      end
      if (SFR_WR && (SFR_ADDR == `U9BG_ADDR_BTCTL)) begin
         bten_d  = SFR_WDATA[`U9BG_BTCTL_EN];
         btdiv_d = SFR_WDATA[2:0];
      end
      if (tx_set) begin
         sctl_d[`U9BG_SCTL_TXDONE] = 1'b1;
      end
      if ((rx_final && rx_ok) || rx_m0_done) begin
         rbuf_d                   = rx_data;
         sctl_d[`U9BG_SCTL_RX9]    = rx_nin;
         sctl_d[`U9BG_SCTL_RXDONE] = 1'b1;
      end
      if (SFR_RD) begin
         case (SFR_ADDR)
            `U9BG_ADDR_SCTL:  rdata_d = sctl_q;
            `U9BG_ADDR_SERIAL_DATA_BUFFER:  rdata_d = rbuf_q;
            `U9BG_ADDR_FDIV:  rdata_d = {2'b00, fdiv_q};
            `U9BG_ADDR_BTCTL: rdata_d = {bten_q, 4'h0, btdiv_q};
            default:          rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         sctl_q  <= `U9BG_RST_SCTL;
         rbuf_q  <= `U9BG_RST_SERIAL_DATA_BUFFER;
         fdiv_q  <= `U9BG_RST_FDIV;
         bten_q  <= 1'b0;
         btdiv_q <= `U9BG_RST_BTDIV;
         rdata_q <= 8'h00;
      end else begin
         sctl_q  <= sctl_d;
         rbuf_q  <= rbuf_d;
         fdiv_q  <= fdiv_d;
         bten_q  <= bten_d;
         btdiv_q <= btdiv_d;
         rdata_q <= rdata_d;
      end
   end
   assign SFR_RDATA = rdata_q;

   // ----------------------------------------
   // Baud-rate generation
   // ----------------------------------------
   logic [3:0]  m0c_q, m0c_d;
   logic        fixh_q, fixh_d;
   logic        t1h_q, t1h_d;
   logic        t2p_q, t2p_d;
   logic [15:0] t2c_q, t2c_d;
   logic [6:0]  pre_q, pre_d;
   logic [7:0]  acc_q, acc_d;
   logic [7:0]  acc_sum;
   logic [6:0]  pre_mask;
   logic        m0_tick, fix_tick, t1_tick, t2_ovf, t2_inc, ded_tick, pre_hit;
   logic        tx_tick16, rx_tick16;

   always_comb begin
      m0c_d   = (m0c_q == `U9BG_M0_LAST) ? 4'h0 : m0c_q + 4'h1;
      m0_tick = (m0c_q == `U9BG_M0_LAST);
      fixh_d  = ~fixh_q;
      // 16x tick every clock or every other
      fix_tick = RATE_DOUBLE || fixh_q;
      t1h_d   = T1_OVF ? ~t1h_q : t1h_q;
      t1_tick = T1_OVF && (RATE_DOUBLE || t1h_q);
      t2p_d   = (TX_CLK_SEL || RX_CLK_SEL) ? ~t2p_q : 1'b0;
      t2_inc  = (TX_CLK_SEL || RX_CLK_SEL) && t2p_q;
      // reload from 16-bit value on overflow
      t2_ovf  = t2_inc && (t2c_q == `U9BG_T2_FULL);
      t2c_d   = (t2_ovf || !(TX_CLK_SEL || RX_CLK_SEL)) ? T2_RELOAD
              : (t2_inc ? t2c_q + 16'h0001 : t2c_q);
      // binary prescale then fractional step of 64
      pre_d    = pre_q + 7'h01;
      pre_mask = 7'((8'h01 << btdiv_q) - 8'h01);
      pre_hit  = ((pre_q & pre_mask) == pre_mask);
      acc_sum  = acc_q + `U9BG_FDIV_OFFSET;
      ded_tick = pre_hit && (acc_sum >= ({2'b00, fdiv_q} + `U9BG_FDIV_OFFSET));
      acc_d    = acc_q;
      if (pre_hit) begin
         acc_d = ded_tick ? acc_sum - ({2'b00, fdiv_q} + `U9BG_FDIV_OFFSET) : acc_sum;
      end
      if (bten_q) begin
         tx_tick16 = ded_tick;
         rx_tick16 = ded_tick;
      end else if (mode == 2'b10) begin
         tx_tick16 = fix_tick;
         rx_tick16 = fix_tick;
      end else begin
         tx_tick16 = TX_CLK_SEL ? t2_ovf : t1_tick;
         rx_tick16 = RX_CLK_SEL ? t2_ovf : t1_tick;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         m0c_q  <= 4'h0;
         fixh_q <= 1'b0;
         t1h_q  <= 1'b0;
         t2p_q  <= 1'b0;
         t2c_q  <= 16'h0000;
         pre_q  <= 7'h00;
         acc_q  <= 8'h00;
      end else begin
         m0c_q  <= m0c_d;
         fixh_q <= fixh_d;
         t1h_q  <= t1h_d;
         t2p_q  <= t2p_d;
         t2c_q  <= t2c_d;
         pre_q  <= pre_d;
         acc_q  <= acc_d;
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   u9bg_pkg::u9bg_tx_state_t tx_st_q, tx_st_d;
   u9bg_pkg::u9bg_rx_state_t rx_st_q, rx_st_d;
   logic [3:0]  txdiv_q, txdiv_d;
   logic [3:0]  txc_q, txc_d;
   logic [10:0] txsh_q, txsh_d;
   logic        txd_q, txd_d, rxo_q, rxo_d, rxoe_q, rxoe_d;
   logic        bit_tick, tx_pop, f_valid;
   logic [7:0]  f_data;
   logic [3:0]  last_pos;

   // buffer writes are queued for sending; a write while the queue is full is dropped
   u9bg_fifo #(.W(8), .D(8)) u_txq (
      .clk       (CLK_SYS),
      .rst       (RESET),
      .in_valid  (wr_serial_data_buffer),
      .in_ready  (TX_FIFO_READY),
      .in_data   (SFR_WDATA),
      .out_valid (f_valid),
      .out_ready (tx_pop),
      .out_data  (f_data)
   );

   always_comb begin
      txdiv_d  = tx_tick16 ? txdiv_q + 4'h1 : txdiv_q;
      bit_tick = m0 ? m0_tick : (tx_tick16 && (txdiv_q == `U9BG_OVS_LAST));
      last_pos = m0 ? `U9BG_M0_LASTBIT : (nine ? `U9BG_STOP_POS9 : `U9BG_STOP_POS8);
      tx_st_d  = tx_st_q;
      txc_d    = txc_q;
      txsh_d   = txsh_q;
      tx_pop   = 1'b0;
      tx_set   = 1'b0;
      case (tx_st_q)
         u9bg_pkg::TX_IDLE: begin
            if (f_valid) begin
               tx_pop  = 1'b1;
               tx_st_d = u9bg_pkg::TX_WAIT;
               if (m0) begin
                  txsh_d = {3'b111, f_data};
               end else begin
                  txsh_d = {1'b1, nine ? sctl_q[`U9BG_SCTL_TX9] : 1'b1, f_data, 1'b0};
               end
            end
         end
         u9bg_pkg::TX_WAIT: begin
            if (bit_tick) begin
               tx_st_d = u9bg_pkg::TX_SHIFT;
               txc_d   = 4'h0;
            end
         end
         u9bg_pkg::TX_SHIFT: begin
            if (bit_tick) begin
               if (txc_q == last_pos) begin
                  tx_st_d = u9bg_pkg::TX_IDLE;
                  tx_set  = m0;
               end else begin
                  txsh_d = {1'b1, txsh_q[10:1]};
                  txc_d  = txc_q + 4'h1;
                  // flag as stop bit goes out
                  tx_set = !m0 && ((txc_q + 4'h1) == last_pos);
               end
            end
         end
         default: tx_st_d = u9bg_pkg::TX_IDLE;
      endcase
      txd_d  = 1'b1;
      rxo_d  = 1'b1;
      rxoe_d = 1'b0;
      if (m0) begin
         txd_d = !((tx_st_q == u9bg_pkg::TX_SHIFT || rx_st_q == u9bg_pkg::RX_DATA)
                   && (m0c_q < `U9BG_M0_HALF));
         rxoe_d = (tx_st_q == u9bg_pkg::TX_SHIFT);
         rxo_d  = txsh_q[0];
      end else if (tx_st_q == u9bg_pkg::TX_SHIFT) begin
         txd_d = txsh_q[0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         tx_st_q <= u9bg_pkg::TX_IDLE;
         txdiv_q <= 4'h0;
         txc_q   <= 4'h0;
         txsh_q  <= 11'h7FF;
         txd_q   <= 1'b1;
         rxo_q   <= 1'b1;
         rxoe_q  <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         txdiv_q <= txdiv_d;
         txc_q   <= txc_d;
         txsh_q  <= txsh_d;
         txd_q   <= txd_d;
         rxo_q   <= rxo_d;
         rxoe_q  <= rxoe_d;
      end
   end
   assign TXD    = txd_q;
   assign RXD_O  = rxo_q;
   assign RXD_OE = rxoe_q;

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   logic [3:0] rxsub_q, rxsub_d;
   logic [3:0] rxc_q, rxc_d;
   logic [8:0] rxsh_q, rxsh_d;
   logic       rxd_prev_q;
   logic       samp;
   logic [3:0] rx_nbits;

   always_comb begin
      rx_st_d    = rx_st_q;
      rxsub_d    = rx_tick16 ? rxsub_q + 4'h1 : rxsub_q;
      rxc_d      = rxc_q;
      rxsh_d     = rxsh_q;
      rx_final   = 1'b0;
      rx_m0_done = 1'b0;
      samp       = m0 ? m0_tick : (rx_tick16 && (rxsub_q == `U9BG_OVS_MID));
      rx_nbits   = nine ? 4'h9 : 4'h8;
      rx_data    = nine ? rxsh_q[7:0] : rxsh_q[8:1];
      rx_nin     = nine ? rxsh_q[8] : RXD_I;
      // stop high, flag clear, address filter
      rx_ok      = !sctl_q[`U9BG_SCTL_RXDONE] && RXD_I &&
                   !(sctl_q[`U9BG_SCTL_MPROC] && nine && !rxsh_q[8]);
      case (rx_st_q)
         u9bg_pkg::RX_IDLE: begin
            if (sctl_q[`U9BG_SCTL_RXEN]) begin
               if (m0) begin
                  if (!sctl_q[`U9BG_SCTL_RXDONE] && tx_st_q == u9bg_pkg::TX_IDLE) begin
                     rx_st_d = u9bg_pkg::RX_DATA;
                     rxc_d   = 4'h0;
                  end
               end else if (rxd_prev_q && !RXD_I) begin
                  rx_st_d = u9bg_pkg::RX_START;
                  rxsub_d = 4'h0;
               end
            end
         end
         u9bg_pkg::RX_START: begin
            if (samp) begin
               rx_st_d = RXD_I ? u9bg_pkg::RX_IDLE : u9bg_pkg::RX_DATA;
               rxc_d   = 4'h0;
            end
         end
         u9bg_pkg::RX_DATA: begin
            if (samp) begin
               rxsh_d = {RXD_I, rxsh_q[8:1]};
               rxc_d  = rxc_q + 4'h1;
               if (m0 && rxc_q == `U9BG_M0_LASTBIT) begin
                  rx_st_d    = u9bg_pkg::RX_IDLE;
                  rx_m0_done = 1'b1;
               end else if (!m0 && (rxc_q + 4'h1) == rx_nbits) begin
                  rx_st_d = u9bg_pkg::RX_STOP;
               end
            end
         end
         u9bg_pkg::RX_STOP: begin
            if (samp) begin
               rx_final = 1'b1;
               rx_st_d  = u9bg_pkg::RX_IDLE;
            end
         end
         default: rx_st_d = u9bg_pkg::RX_IDLE;
      endcase
      if (rx_m0_done) begin
         rx_data = {RXD_I, rxsh_q[8:2]};
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_st_q    <= u9bg_pkg::RX_IDLE;
         rxsub_q    <= 4'h0;
         rxc_q      <= 4'h0;
         rxsh_q     <= 9'h000;
         rxd_prev_q <= 1'b1;
      end else begin
         rx_st_q    <= rx_st_d;
         rxsub_q    <= rxsub_d;
         rxc_q      <= rxc_d;
         rxsh_q     <= rxsh_d;
         rxd_prev_q <= RXD_I;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_tx_idle_high: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (tx_st_q == u9bg_pkg::TX_IDLE && !m0) |=> TXD) else $error("line not idle high");
   a_tx_start_low: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (tx_st_q == u9bg_pkg::TX_WAIT && bit_tick && !m0) |=> ##1 !TXD)
      else $error("start bit not low");
   a_tx_wait_tick: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (tx_st_q == u9bg_pkg::TX_WAIT && !bit_tick) |=> tx_st_q == u9bg_pkg::TX_WAIT)
      else $error("shift began off tick");
   a_tx_done_set: assert property (@(posedge CLK_SYS) disable iff (RESET)
      tx_set |=> sctl_q[`U9BG_SCTL_TXDONE]) else $error("tx done flag lost");
   a_rx_accept: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (rx_final && rx_ok) |=> (sctl_q[`U9BG_SCTL_RXDONE] && rbuf_q == $past(rx_data)))
      else $error("frame not latched");
   a_rx_reject: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (rx_final && !rx_ok && !wr_sctl) |=>
      sctl_q[`U9BG_SCTL_RXDONE] == $past(sctl_q[`U9BG_SCTL_RXDONE]))
      else $error("bad frame changed flag");
   a_buf_write_sends: assert property (@(posedge CLK_SYS) disable iff (RESET)
      (wr_serial_data_buffer && TX_FIFO_READY) |=> (f_valid || tx_st_q != u9bg_pkg::TX_IDLE))
      else $error("write did not queue");
   a_m0_rate: assert property (@(posedge CLK_SYS) disable iff (RESET)
      m0_tick |=> !m0_tick [*8] ##1 !m0_tick [*3] ##1 m0_tick)
      else $error("shift rate not clock/12");
   a_t2_half_rate: assert property (@(posedge CLK_SYS) disable iff (RESET)
      t2_inc |=> !t2_inc) else $error("timer 2 counts too fast");
   a_ctl_readback: assert property (@(posedge CLK_SYS) disable iff (RESET)
      $past(SFR_RD && SFR_ADDR == `U9BG_ADDR_BTCTL) |-> SFR_RDATA[6:3] == 4'h0)
      else $error("unused control bits read set");
endmodule // u9bg_top
`default_nettype wire

// >>> u9bg_map.svh
// Address map, field positions, reset values and timing counts of the serial block
`ifndef U9BG_MAP_SVH
`define U9BG_MAP_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define U9BG_ADDR_SCTL      8'h98
`define U9BG_ADDR_SERIAL_DATA_BUFFER      8'h99
`define U9BG_ADDR_FDIV      8'h9D
`define U9BG_ADDR_BTCTL     8'h9E
// ----------------------------------------
// Reset values
// ----------------------------------------
`define U9BG_RST_SCTL       8'h00
`define U9BG_RST_SERIAL_DATA_BUFFER       8'h00
`define U9BG_RST_FDIV       6'h00
`define U9BG_RST_BTDIV      3'h0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define U9BG_SCTL_MODE_HI   7
`define U9BG_SCTL_MODE_LO   6
`define U9BG_SCTL_MPROC     5
`define U9BG_SCTL_RXEN      4
`define U9BG_SCTL_TX9       3
`define U9BG_SCTL_RX9       2
`define U9BG_SCTL_TXDONE    1
`define U9BG_SCTL_RXDONE    0
`define U9BG_BTCTL_EN       7
`define U9BG_FDIV_OFFSET    8'h40
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define U9BG_M0_LAST        4'hB
`define U9BG_M0_HALF        4'h6
`define U9BG_OVS_LAST       4'hF
`define U9BG_OVS_MID        4'h7
`define U9BG_T2_FULL        16'hFFFF
`define U9BG_STOP_POS9      4'hA
`define U9BG_STOP_POS8      4'h9
`define U9BG_M0_LASTBIT     4'h7
`endif

// >>> u9bg_pkg.sv
// Types shared by the serial block
package u9bg_pkg;
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_WAIT  = 2'b01,
      TX_SHIFT = 2'b11
   } u9bg_tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } u9bg_rx_state_t;
endpackage

// >>> u9bg_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module u9bg_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_q, wr_d;
   logic [AW:0]  rd_q, rd_d;
   logic         push;
   logic         pop;

   always_comb begin
      in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
      out_valid = (wr_q != rd_q);
      push      = in_valid && in_ready;
      pop       = out_valid && out_ready;
      wr_d      = push ? wr_q + 1'b1 : wr_q;
      rd_d      = pop ? rd_q + 1'b1 : rd_q;
      out_data  = mem[rd_q[AW-1:0]];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
endmodule // u9bg_fifo
`default_nettype wire

// >>> u9bg_remote.sv
// Remote asynchronous station facing the serial block
`timescale 1ns/1ps
`default_nettype none
module u9bg_remote (
   // Clock and bit length in core clocks
   input  wire logic       clk,
   input  wire logic [7:0] bit_len,
   // Serial lines
   input  wire logic       line_in,
   output logic            line_out
);
   logic [9:0] shreg;
   logic [7:0] got_data;
   logic       got_ninth;
   logic       got_stop;
   int         got_count;
   initial begin
      line_out  = 1'b1;
      got_count = 0;
   end
   // start, data LSB first, ninth, stop
   task automatic send(input logic [8:0] w, input logic stop);
      logic [10:0] f;
      f = {stop, w, 1'b0};
      for (int i = 0; i < 11; i++) begin
         line_out = f[i];
         repeat (bit_len) @(negedge clk);
      end
      line_out = 1'b1;
      repeat (bit_len) @(negedge clk);
   endtask
   // frames from the device, sampled mid-bit
   always begin
      @(negedge line_in);
      repeat (bit_len / 2) @(negedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (bit_len) @(negedge clk);
         shreg[i] = line_in;
      end
      {got_stop, got_ninth, got_data} = shreg;
      got_count++;
   end
endmodule // u9bg_remote
`default_nettype wire

// >>> test_uart_nine_bit_and_baud_gen.sv
// Self-checking bench for the nine-bit serial block
`timescale 1ns/1ps
`default_nettype none
module test_uart_nine_bit_and_baud_gen;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        clk_sys;
   logic        reset;
   logic [7:0]  sfr_addr;
   logic        sfr_wr;
   logic [7:0]  sfr_wdata;
   logic        sfr_rd;
   logic [7:0]  sfr_rdata;
   logic        tx_fifo_ready;
   logic        rate_double;
   logic        tx_clk_sel;
   logic        rx_clk_sel;
   logic        t1_ovf;
   logic        t1_run;
   logic [15:0] t2_reload;
   logic        txd;
   logic        rxd;
   logic        rxd_oe;
   logic        rxd_o;
   logic [7:0]  m0_shift;
   logic [7:0]  bit_len;
   logic [7:0]  rv;
   logic [23:0] rows [5];
   int          n;
   int          failures;
   int          check_count;
   u9bg_top dut (
      .CLK_SYS(clk_sys), .RESET(reset), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
      .SFR_WDATA(sfr_wdata), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata),
      .TX_FIFO_READY(tx_fifo_ready), .RATE_DOUBLE(rate_double),
      .TX_CLK_SEL(tx_clk_sel), .RX_CLK_SEL(rx_clk_sel), .T1_OVF(t1_ovf),
      .T2_RELOAD(t2_reload), .TXD(txd), .RXD_I(rxd), .RXD_O(rxd_o), .RXD_OE(rxd_oe)
   );
   u9bg_remote remote (
      .clk(clk_sys), .bit_len(bit_len), .line_in(txd), .line_out(rxd)
   );
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // auto-reload overflow every two clocks, no interrupt
   always @(negedge clk_sys) t1_ovf <= t1_run & ~t1_ovf;
   // Shift-mode data seen at each rising shift clock
   always @(posedge txd) if (rxd_oe) m0_shift <= {rxd_o, m0_shift[7:1]};
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      d = sfr_rdata;
      @(negedge clk_sys);
   endtask
   task automatic results();
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_frames(input int target);
      int k;
      k = 0;
      while (remote.got_count < target && k < 8000) begin
         @(negedge clk_sys);
         k++;
      end
      if (k >= 8000) begin
         failures++;
         $display("BAD frame wait expected %0d seen %0d", target, remote.got_count);
         results();
      end
   endtask
   task automatic tx_frame(input logic [7:0] ctl, input logic [7:0] d, input logic [7:0] bl);
      int n0;
      n0 = remote.got_count;
      bit_len = bl;
      wr(8'h98, ctl);
      wr(8'h99, d);
      wait_frames(n0 + 1);
      chk("tx data", d, remote.got_data);
      chk("tx ninth stop", {6'h00, ctl[3], 1'b1}, {6'h00, remote.got_ninth, remote.got_stop});
      rd(8'h98, rv);
      chk("tx done", ctl | 8'h02, rv);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      failures = 0;
      check_count = 0;
      reset = 1'b1;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      sfr_rd = 1'b0;
      rate_double = 1'b1;
      tx_clk_sel = 1'b0;
      rx_clk_sel = 1'b0;
      t1_run = 1'b0;
      t1_ovf = 1'b0;
      t2_reload = 16'h0000;
      bit_len = 8'h10;
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      rd(8'h9E, rv);
      chk("rate control reset", 8'h00, rv);
      rd(8'h9D, rv);
      chk("fraction reset", 8'h00, rv);
      chk("pins reset", 8'h05, {5'h00, txd, rxd_oe, tx_fifo_ready});
      rows = '{24'h9E_FF87, 24'h9D_FF3F, 24'h9E_0000, 24'h90_AA00, 24'h9D_1212};
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16], rv);
         chk("register", rows[i][7:0], rv);
      end
      tx_frame(8'h88, 8'hA5, 8'h10);
      rate_double = 1'b0;
      tx_frame(8'h80, 8'h5A, 8'h20);
      rate_double = 1'b1;
      t1_run = 1'b1;
      tx_frame(8'hC8, 8'h81, 8'h20);
      tx_frame(8'h48, 8'h96, 8'h20);
      wr(8'h9E, 8'h81);
      wr(8'h9D, 8'h00);
      tx_clk_sel = 1'b1;
      t2_reload = 16'hFFFE;
      tx_frame(8'hC0, 8'h3C, 8'h20);
      wr(8'h9E, 8'h00);
      tx_clk_sel = 1'b0;
      bit_len = 8'h10;
      wr(8'h98, 8'h80);
      n = remote.got_count;
      for (int i = 0; i < 11; i++) wr(8'h99, i[7:0]);
      chk("queue full", 8'h00, {7'h00, tx_fifo_ready});
      wait_frames(n + 9);
      chk("last queued", 8'h08, remote.got_data);
      repeat (400) @(negedge clk_sys);
      chk("frame count", 8'h09, 8'(remote.got_count - n));
      remote.send(9'h1C3, 1'b1);
      rd(8'h98, rv);
      chk("rx disabled", 8'h82, rv);
      wr(8'h98, 8'h90);
      remote.send(9'h13C, 1'b1);
      rd(8'h99, rv);
      chk("rx data", 8'h3C, rv);
      rd(8'h98, rv);
      chk("rx flags", 8'h95, rv);
      remote.send(9'h055, 1'b1);
      rd(8'h99, rv);
      chk("rx held", 8'h3C, rv);
      wr(8'h98, 8'h90);
      remote.send(9'h166, 1'b0);
      rd(8'h98, rv);
      chk("bad stop", 8'h90, rv);
      remote.send(9'h066, 1'b1);
      rd(8'h99, rv);
      chk("rx next", 8'h66, rv);
      rd(8'h98, rv);
      chk("rx ninth clear", 8'h91, rv);
      rx_clk_sel = 1'b1;
      bit_len = 8'h40;
      wr(8'h98, 8'hD0);
      remote.send(9'h1A9, 1'b1);
      rd(8'h99, rv);
      chk("rx timer 2 data", 8'hA9, rv);
      rd(8'h98, rv);
      chk("rx timer 2 flags", 8'hD5, rv);
      rx_clk_sel = 1'b0;
      wr(8'h98, 8'h00);
      wr(8'h99, 8'h5B);
      repeat (150) @(negedge clk_sys);
      rd(8'h98, rv);
      chk("shift done", 8'h02, rv);
      chk("shift data", 8'h5B, m0_shift);
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      rd(8'h98, rv);
      chk("control after reset", 8'h00, rv);
      results();
   end
endmodule // test_uart_nine_bit_and_baud_gen
`default_nettype wire
